// ---- hw/acsc_setup_ctrl.sv ----
// conversion setup registers and conversion sequencing control
`include "acsc_consts.svh"
module acsc_setup_ctrl import acsc_pkg::*; (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic master_clock_in, // converter master clock pin
  input wire logic frame_done, // last bit of a register frame
  input wire acsc_frame_t frame, // register, direction and data
  output logic [7:0] rd_data_q, // read answer of last frame
  output logic result_ready_q, // new settled data available
  output acsc_chan_t conv_chan_q, // channel being converted
  output logic [1:0] tf_sel_q, // transfer register in use
  output logic filter_reset_q, // modulator and filter in reset
  output logic sinc1_sel_q, // first-order filter selected
  output logic sample_done_q, // one word finished
  output logic [1:0] mod_ratio_q, // modulator clock ratio
  output logic input_buffer_en_q, // input buffers powered
  output logic input_mode_a_q, // differential input pairs
  output logic burnout_source_en_q, // test currents connected
  output logic clock_prescale_half_q // master clock halved
);
  // register state
  acsc_setup1_t setup1_q;
  acsc_setup2_t setup2_q;
  logic [7:0] command_register_q;
  acsc_state_t state_q, state_d;
  logic [1:0] settle_q;
  logic [1:0] seq_tf;
  acsc_chan_t seq_chan;
  logic sample_pulse;

  // master clock pin synchroniser and edge detect
  logic mclk_s1_q, mclk_s2_q, mclk_s3_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
    end else begin
      mclk_s1_q <= master_clock_in;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
    end
  end
  wire master_edge = mclk_s2_q & ~mclk_s3_q;

  // frame decode, acting only on the end-of-frame strobe
  wire is_wr = frame_done & ~frame.rd;
  wire is_rd = frame_done & frame.rd;
  wire wr_command_register = is_wr & (frame.reg_sel == `ACSC_RS_COMMAND_REGISTER);
  wire wr_setup1 = is_wr & (frame.reg_sel == `ACSC_RS_SETUP1);
  wire wr_setup2 = is_wr & (frame.reg_sel == `ACSC_RS_SETUP2);
  wire rd_data_reg = is_rd & (frame.reg_sel == `ACSC_RS_DATA);

  // a setup change resets the filter, writes of equal value do not
  wire chg1 = wr_setup1 & (frame.data != setup1_q);
  wire chg2 = wr_setup2 & (frame.data != setup2_q);
  wire cfg_change = chg1 | chg2;
  wire hold = command_register_q[`ACSC_COMMAND_REGISTER_HOLD_BIT];

  // setup and command registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      setup1_q <= `ACSC_SETUP1_RST;
      setup2_q <= `ACSC_SETUP2_RST;
      command_register_q <= `ACSC_COMMAND_REGISTER_RST;
    end else begin
      if (wr_setup1) setup1_q <= frame.data;
      if (wr_setup2) setup2_q <= frame.data;
      if (wr_command_register) command_register_q <= frame.data;
    end
  end

  // decimation period in master ticks from the rate table
  logic [15:0] per_base;
  always_comb begin
    case ({setup1_q.clk_range, setup1_q.decim_sel})
      3'h0: per_base = `ACSC_PER_LO_F0;
      3'h1: per_base = `ACSC_PER_LO_F1;
      3'h2: per_base = `ACSC_PER_LO_F2;
      3'h3: per_base = `ACSC_PER_LO_F3;
      3'h4: per_base = `ACSC_PER_HI_F0;
      3'h5: per_base = `ACSC_PER_HI_F1;
      3'h6: per_base = `ACSC_PER_HI_F2;
      default: per_base = `ACSC_PER_HI_F3;
    endcase
  end
  // each modulator ratio step halves the period, doubling the rate
  wire [15:0] period = per_base >> setup1_q.mod_ratio;

  // filter and modulator sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: if (!hold) state_d = ST_RESTART;
      // a change while restarting keeps the filter in reset one more cycle
      ST_RESTART: state_d = hold ? ST_HOLD : (cfg_change ? ST_RESTART : ST_CONVERT);
      ST_CONVERT: begin
        if (hold) state_d = ST_HOLD;
        else if (cfg_change) state_d = ST_RESTART;
      end
      default: state_d = ST_RESTART;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) state_q <= ST_RESTART;
    else state_q <= state_d;
  end

  wire running = (state_q == ST_CONVERT) & ~cfg_change;
  wire timer_restart = (state_q != ST_CONVERT) | cfg_change;
  wire word_done = sample_pulse & running;

  // output word timer
  acsc_rate_gen u_rate (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .master_edge(master_edge),
    .prescale(setup2_q.clock_prescale_half),
    .period(period),
    .restart(timer_restart),
    .sample_pulse(sample_pulse)
  );

  // channel selection and scanning
  acsc_chan_seq u_seq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .s1(setup1_q),
    .s2(setup2_q),
    .advance(word_done),
    .restart(timer_restart),
    .chan(seq_chan),
    .tf_sel(seq_tf)
  );

  // words needed after a filter reset before data counts as settled
  wire [1:0] settle_need = setup1_q.fast ? `ACSC_SETTLE_SINC1 : `ACSC_SETTLE_SINC3;
  wire settled_word = word_done & (settle_q >= settle_need - 2'h1);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) settle_q <= 2'h0;
    else if (timer_restart) settle_q <= 2'h0;
    else if (word_done && !settled_word) settle_q <= settle_q + 2'h1;
  end

  // ready flag: a settled word beats a data read in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) result_ready_q <= 1'b0;
    else if (cfg_change) result_ready_q <= 1'b0;
    else if (settled_word) result_ready_q <= 1'b1;
    else if (rd_data_reg) result_ready_q <= 1'b0;
  end

  // read answers; data register shows the channel of the last word
  logic [3:0] last_chan_q;
  wire [7:0] command_register_rd = {result_ready_q, command_register_q[6:0]};
  wire [7:0] rd_mux =
    (frame.reg_sel == `ACSC_RS_COMMAND_REGISTER) ? command_register_rd :
    (frame.reg_sel == `ACSC_RS_SETUP1) ? setup1_q :
    (frame.reg_sel == `ACSC_RS_SETUP2) ? setup2_q :
    (frame.reg_sel == `ACSC_RS_DATA) ? {4'h0, last_chan_q} : 8'h00;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= 8'h00;
      last_chan_q <= 4'h0;
    end else begin
      if (is_rd) rd_data_q <= rd_mux;
      if (word_done) last_chan_q <= seq_chan;
    end
  end

  // registered outputs steering the analog front end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      conv_chan_q <= CH_AIN1_COM;
      tf_sel_q <= 2'h1;
      filter_reset_q <= 1'b1;
      sinc1_sel_q <= 1'b0;
      sample_done_q <= 1'b0;
      mod_ratio_q <= 2'h0;
      input_buffer_en_q <= 1'b0;
      input_mode_a_q <= 1'b0;
      burnout_source_en_q <= 1'b0;
      clock_prescale_half_q <= 1'b0;
    end else begin
      conv_chan_q <= seq_chan;
      tf_sel_q <= seq_tf;
      filter_reset_q <= timer_restart;
      sinc1_sel_q <= setup1_q.fast;
      sample_done_q <= word_done;
      mod_ratio_q <= setup1_q.mod_ratio;
      input_buffer_en_q <= setup2_q.input_buffer_en;
      input_mode_a_q <= setup2_q.input_mode_a;
      burnout_source_en_q <= setup2_q.burnout_source_en;
      clock_prescale_half_q <= setup2_q.clock_prescale_half;
    end
  end

  // checks on the sequencing
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_hold_no_words: assert property (
    (state_q == ST_HOLD) |-> !word_done ##1 !sample_done_q)
    else $error("word finished while hold active");

  a_hold_in_reset: assert property (
    (hold && state_q == ST_CONVERT) |=> ##1 filter_reset_q)
    else $error("filter not reset under hold");

  a_hold_ready_kept: assert property (
    (wr_command_register && !settled_word && !cfg_change) |=> $stable(result_ready_q))
    else $error("command write disturbed ready flag");

  a_read_clears: assert property (
    (rd_data_reg && !settled_word && !cfg_change) |=> !result_ready_q)
    else $error("data read left ready set");

  a_change_drops: assert property (
    cfg_change |=> !result_ready_q ##1 filter_reset_q)
    else $error("setup change kept ready or filter running");

  a_sinc3_settle: assert property (
    ($rose(result_ready_q) && !$past(setup1_q.fast)) |-> $past(settle_q) == 2'h2)
    else $error("third-order ready before three words");

  a_sinc1_settle: assert property (
    ($rose(result_ready_q) && $past(setup1_q.fast)) |-> $past(settle_q) == 2'h0)
    else $error("first-order ready not on first word");

  a_order_switch: assert property (
    (wr_setup1 && setup1_q.fast && !frame.data[0]) |=> !result_ready_q [*2])
    else $error("ready kept across filter order switch");

  a_frame_only: assert property (
    !wr_setup1 |=> $stable(setup1_q))
    else $error("setup one changed outside a frame end");

  a_rate_period: assert property (
    (setup1_q == 8'h0a && setup2_q.clock_prescale_half == 1'b0) |->
    period == 16'ha000)
    else $error("default rate period wrong");

  // front-end mirrors trail the setup registers by one cycle
  a_ratio_mirror: assert property (
    mod_ratio_q == $past(setup1_q.mod_ratio))
    else $error("modulator ratio output out of step");

  a_sinc_mirror: assert property (
    sinc1_sel_q == $past(setup1_q.fast))
    else $error("filter order output out of step");

  a_buffer_mirror: assert property (
    input_buffer_en_q == $past(setup2_q.input_buffer_en))
    else $error("buffer enable output out of step");

  a_input_mode_a_mirror: assert property (
    input_mode_a_q == $past(setup2_q.input_mode_a))
    else $error("input mode output out of step");

  a_burnout_mirror: assert property (
    burnout_source_en_q == $past(setup2_q.burnout_source_en))
    else $error("burnout output out of step");

  a_prescale_mirror: assert property (
    clock_prescale_half_q == $past(setup2_q.clock_prescale_half))
    else $error("prescale output out of step");

  // channel choice seen on the front-end outputs
  a_chan_fixed: assert property (
    (!setup2_q.scan && setup2_q.cal_mode == 2'h0 && !setup2_q.input_mode_a) |=>
    4'(conv_chan_q) == {2'h0, $past(setup1_q.chan_sel)})
    else $error("fixed channel not taken from select bits");

  a_cal_offset: assert property (
    (!setup2_q.scan && setup2_q.cal_mode == 2'h1) |=> conv_chan_q == CH_OFFSET_CAL_INPUT)
    else $error("offset calibration input not selected");

  a_cal_gain: assert property (
    (!setup2_q.scan && setup2_q.cal_mode == 2'h2) |=> conv_chan_q == CH_GAIN_CAL_INPUT)
    else $error("gain calibration input not selected");

  a_scan_cal_tf: assert property (
    (setup2_q.scan && (seq_chan == CH_OFFSET_CAL_INPUT || seq_chan == CH_GAIN_CAL_INPUT)) |=>
    tf_sel_q == 2'h3)
    else $error("scanned calibration input not on third transfer register");

  // sequencing between hold, restart and conversion
  a_hold_state: assert property (
    (hold && state_q == ST_CONVERT) |=> state_q == ST_HOLD)
    else $error("hold did not stop conversions");

  a_restart_runs: assert property (
    (state_q == ST_RESTART && !hold && !cfg_change) |=> state_q == ST_CONVERT)
    else $error("conversions did not resume after restart");

  a_idle_no_words: assert property (
    (state_q != ST_CONVERT) |=> !sample_done_q)
    else $error("word reported while not converting");

  // ready flag against settling and reads
  a_early_words: assert property (
    (word_done && !setup1_q.fast && settle_q < 2'h2) |=> !$rose(result_ready_q))
    else $error("third-order ready raised on an unsettled word");

  a_ready_set: assert property (
    (word_done && setup1_q.fast) |=> result_ready_q)
    else $error("first-order word did not raise ready");

  a_ready_kept_hold: assert property (
    (state_q == ST_HOLD && !rd_data_reg && !cfg_change) |=> $stable(result_ready_q))
    else $error("hold disturbed ready flag");

  // read answers and frame-end updates
  a_setup1_read: assert property (
    (is_rd && frame.reg_sel == `ACSC_RS_SETUP1) |=> rd_data_q == $past(setup1_q))
    else $error("setup one read answer wrong");

  a_data_read: assert property (
    rd_data_reg |=> rd_data_q == {4'h0, $past(last_chan_q)})
    else $error("data read answer wrong");

  a_setup2_frame: assert property (
    !wr_setup2 |=> $stable(setup2_q))
    else $error("setup two changed outside a frame end");
endmodule

// ---- hw/acsc_consts.svh ----
// register addresses, field positions, reset values and rate counts
`ifndef ACSC_CONSTS_SVH
`define ACSC_CONSTS_SVH

// register select codes carried in the reg_sel field of each frame
`define ACSC_RS_COMMAND_REGISTER 3'h0
`define ACSC_RS_SETUP1 3'h1
`define ACSC_RS_SETUP2 3'h2
`define ACSC_RS_DATA 3'h7

// reset values of the setup and command registers
`define ACSC_SETUP1_RST 8'h0a
`define ACSC_SETUP2_RST 8'h00
`define ACSC_COMMAND_REGISTER_RST 8'h00

// command register bit positions
`define ACSC_COMMAND_REGISTER_HOLD_BIT 0
`define ACSC_COMMAND_REGISTER_READY_BIT 7

// master clock ticks per output word, slowest modulator setting
`define ACSC_PER_LO_F0 16'hc800
`define ACSC_PER_LO_F1 16'ha000
`define ACSC_PER_LO_F2 16'h2800
`define ACSC_PER_LO_F3 16'h1400
`define ACSC_PER_HI_F0 16'hc000
`define ACSC_PER_HI_F1 16'ha000
`define ACSC_PER_HI_F2 16'h2000
`define ACSC_PER_HI_F3 16'h1000

// output words needed to settle each filter order
`define ACSC_SETTLE_SINC3 2'h3
`define ACSC_SETTLE_SINC1 2'h1

`endif

// ---- hw/acsc_pkg.sv ----
// types shared by the conversion setup control block
package acsc_pkg;

  typedef struct packed {
    logic [1:0] chan_sel;
    logic [1:0] mod_ratio;
    logic clk_range;
    logic [1:0] decim_sel;
    logic fast;
  } acsc_setup1_t;

  typedef struct packed {
    logic scan;
    logic [1:0] cal_mode;
    logic input_buffer_en;
    logic input_mode_a;
    logic burnout_source_en;
    logic rsvd;
    logic clock_prescale_half;
  } acsc_setup2_t;

  typedef struct packed {
    logic [2:0] reg_sel;
    logic rd;
    logic [7:0] data;
  } acsc_frame_t;

  typedef enum logic [3:0] {
    CH_AIN1_COM, CH_AIN2_COM, CH_AIN3_COM, CH_AIN4_COM, CH_AIN5_COM,
    CH_PAIR12, CH_PAIR34, CH_PAIR56, CH_OFFSET_CAL_INPUT, CH_GAIN_CAL_INPUT
  } acsc_chan_t;

  typedef enum logic [1:0] {ST_HOLD, ST_RESTART, ST_CONVERT} acsc_state_t;

endpackage

// ---- hw/acsc_rate_gen.sv ----
// output word timer driven by master clock edges, with prescaler
module acsc_rate_gen import acsc_pkg::*; (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // async reset
  input wire logic master_edge, // one rising master clock edge
  input wire logic prescale, // divide master clock by two
  input wire logic [15:0] period, // master ticks per word
  input wire logic restart, // hold timer at zero
  output logic sample_pulse // one word finished
);
  logic phase_q;
  logic [15:0] cnt_q;
  wire tick_en = master_edge & (~prescale | phase_q);
  wire at_end = (cnt_q == period - 16'h0001);

  // prescaler phase and word counter
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= 1'b0;
      cnt_q <= 16'h0000;
      sample_pulse <= 1'b0;
    end else if (restart) begin
      phase_q <= 1'b0;
      cnt_q <= 16'h0000;
      sample_pulse <= 1'b0;
    end else begin
      phase_q <= master_edge ? ~phase_q : phase_q;
      cnt_q <= tick_en ? (at_end ? 16'h0000 : cnt_q + 16'h0001) : cnt_q;
      sample_pulse <= tick_en & at_end;
    end
  end

  a_prescale_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!restart && master_edge && prescale && !phase_q) |=> $stable(cnt_q))
    else $error("prescaler let a master edge count");
endmodule

// ---- hw/acsc_chan_seq.sv ----
// conversion channel choice, fixed or scanned
module acsc_chan_seq import acsc_pkg::*; (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // async reset
  input wire acsc_setup1_t s1, // setup one
  input wire acsc_setup2_t s2, // setup two
  input wire logic advance, // word finished
  input wire logic restart, // back to first channel
  output acsc_chan_t chan, // channel to convert
  output logic [1:0] tf_sel // transfer register 1..3
);
  logic [2:0] idx_q;
  wire cal_both = s2.cal_mode[1] ^ s2.cal_mode[0];
  wire [2:0] base_n = s2.input_mode_a ? 3'h3 : 3'h5;
  wire [2:0] last = base_n + (cal_both ? 3'h2 : 3'h0) - 3'h1;

  // scan position
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) idx_q <= 3'h0;
    else if (restart || !s2.scan) idx_q <= 3'h0;
    else if (advance) idx_q <= (idx_q >= last) ? 3'h0 : idx_q + 3'h1;
  end

  // channel and its transfer register
  always_comb begin
    chan = CH_AIN1_COM;
    tf_sel = 2'h1;
    if (s2.scan) begin
      if (idx_q >= base_n) begin
        chan = (idx_q == base_n) ? CH_OFFSET_CAL_INPUT : CH_GAIN_CAL_INPUT;
        tf_sel = 2'h3;
      end else if (s2.input_mode_a) begin
        chan = acsc_chan_t'(4'(CH_PAIR12) + {1'b0, idx_q});
        tf_sel = 2'(idx_q) + 2'h1;
      end else begin
        chan = acsc_chan_t'({1'b0, idx_q});
        tf_sel = (idx_q < 3'h2) ? 2'h1 : ((idx_q < 3'h4) ? 2'h2 : 2'h3);
      end
    end else begin
      tf_sel = s2.input_mode_a ? (s1.chan_sel == 2'h3 ? 2'h3 : s1.chan_sel + 2'h1)
                               : (s1.chan_sel[1] ? 2'h2 : 2'h1);
      case (s2.cal_mode)
        2'h1: chan = CH_OFFSET_CAL_INPUT;
        2'h2: chan = CH_GAIN_CAL_INPUT;
        default: chan = s2.input_mode_a
          ? acsc_chan_t'(4'(CH_PAIR12) + {2'h0, (s1.chan_sel == 2'h3) ? 2'h2 : s1.chan_sel})
          : acsc_chan_t'({2'h0, s1.chan_sel});
      endcase
    end
  end

  a_scan_wraps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s2.scan && !restart && advance && idx_q == last) |=> idx_q == 3'h0)
    else $error("scan did not wrap to first channel");
endmodule

// ---- test/acsc_host_model.sv ----
// host side model that sends whole register frames to the setup control block
`include "acsc_consts.svh"
module acsc_host_model import acsc_pkg::*; (
  input wire logic clk_sys, // system clock
  output logic frame_done, // last bit of a frame received
  output acsc_frame_t frame, // register, direction and data
  input wire logic [7:0] rd_data_q // read answer
);
  timeunit 1ns;
  timeprecision 1ns;

  // lines quiet at time zero
  initial begin
    frame_done = 1'b0;
    frame = '0;
  end

  // one frame: raised after a falling edge, held over the taking edge
  task automatic xfer(input logic [2:0] sel, input logic rd, input logic [7:0] wdata,
      output logic [7:0] rdata);
    acsc_frame_t f;
    f.reg_sel = sel;
    f.rd = rd;
    f.data = (sel == `ACSC_RS_SETUP2 && !rd) ? (wdata & 8'hfd) : wdata;
    @(negedge clk_sys);
    frame = f;
    frame_done = 1'b1;
    @(negedge clk_sys);
    frame_done = 1'b0;
    frame = ~f; // released lines do not keep the old value
    @(negedge clk_sys);
    rdata = rd_data_q;
  endtask
endmodule

// ---- test/acsc_setup_ctrl_tb.sv ----
// self-checking bench for the conversion setup control block
`include "acsc_consts.svh"
`define ACSC_CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); \
  end \
end
module acsc_setup_ctrl_tb import acsc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic master_clock_in = 1'b0;
  logic frame_done;
  acsc_frame_t frame;
  logic [7:0] rd_data_q;
  logic result_ready_q;
  acsc_chan_t conv_chan_q;
  logic [1:0] tf_sel_q;
  logic filter_reset_q;
  logic sinc1_sel_q;
  logic sample_done_q;
  logic [1:0] mod_ratio_q;
  logic input_buffer_en_q;
  logic input_mode_a_q;
  logic burnout_source_en_q;
  logic clock_prescale_half_q;
  int failures = 0;
  int compares = 0;

  // system clock and a fast master clock, one rising edge per 4 cycles
  always #5 clk_sys = ~clk_sys;
  always #20 master_clock_in = ~master_clock_in;

  acsc_setup_ctrl i_acsc_setup_ctrl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .master_clock_in(master_clock_in),
    .frame_done(frame_done), .frame(frame), .rd_data_q(rd_data_q),
    .result_ready_q(result_ready_q), .conv_chan_q(conv_chan_q), .tf_sel_q(tf_sel_q),
    .filter_reset_q(filter_reset_q), .sinc1_sel_q(sinc1_sel_q),
    .sample_done_q(sample_done_q), .mod_ratio_q(mod_ratio_q),
    .input_buffer_en_q(input_buffer_en_q), .input_mode_a_q(input_mode_a_q),
    .burnout_source_en_q(burnout_source_en_q),
    .clock_prescale_half_q(clock_prescale_half_q)
  );

  acsc_host_model i_acsc_host_model (
    .clk_sys(clk_sys), .frame_done(frame_done), .frame(frame), .rd_data_q(rd_data_q)
  );

  // register access helpers
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    logic [7:0] unused;
    i_acsc_host_model.xfer(sel, 1'b0, d, unused);
  endtask
  task automatic rd(input logic [2:0] sel, output logic [7:0] d);
    i_acsc_host_model.xfer(sel, 1'b1, 8'h00, d);
  endtask

  // cycles until the next finished word, bounded
  task automatic wait_word(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (sample_done_q !== 1'b1 && n < 20000);
    if (sample_done_q !== 1'b1) failures++;
  endtask

  // reset values of the registers
  task automatic t_reset();
    logic [7:0] d;
    `ACSC_CHK(result_ready_q, 1'b0)
    rd(`ACSC_RS_SETUP1, d);
    `ACSC_CHK(d, 8'h0a)
    rd(`ACSC_RS_SETUP2, d);
    `ACSC_CHK(d, 8'h00)
    rd(3'h3, d);
    `ACSC_CHK(d, 8'h00)
  endtask

  // word period for several rate settings, first-order filter
  task automatic t_rate();
    logic [7:0] cfg [4] = '{8'h3f, 8'h3d, 8'h37, 8'h2f};
    int exp_clk [4] = '{2048, 4096, 2560, 4096};
    int n;
    foreach (cfg[i]) begin
      wr(`ACSC_RS_SETUP1, cfg[i]);
      wait_word(n);
      `ACSC_CHK(result_ready_q, 1'b1)
      wait_word(n);
      `ACSC_CHK(n, exp_clk[i])
    end
  endtask

  // switch to third-order filter: ready waits for three words
  task automatic t_sinc3();
    int n;
    wr(`ACSC_RS_SETUP1, 8'h3e);
    `ACSC_CHK(result_ready_q, 1'b0)
    repeat (2) begin
      wait_word(n);
      `ACSC_CHK(result_ready_q, 1'b0)
    end
    wait_word(n);
    `ACSC_CHK(result_ready_q, 1'b1)
    `ACSC_CHK(sinc1_sel_q, 1'b0)
  endtask

  // hold: no words, ready kept, data read clears ready
  task automatic t_hold();
    logic [7:0] d;
    int n;
    wr(`ACSC_RS_COMMAND_REGISTER, 8'h01);
    repeat (2) @(negedge clk_sys);
    `ACSC_CHK(filter_reset_q, 1'b1)
    n = 0;
    repeat (6000) begin
      @(negedge clk_sys);
      if (sample_done_q === 1'b1) n++;
    end
    `ACSC_CHK(n, 0)
    rd(`ACSC_RS_COMMAND_REGISTER, d);
    `ACSC_CHK(d, 8'h81)
    rd(`ACSC_RS_DATA, d);
    `ACSC_CHK(result_ready_q, 1'b0)
    `ACSC_CHK(filter_reset_q, 1'b1)
    wr(`ACSC_RS_COMMAND_REGISTER, 8'h00);
  endtask

  // fixed channel from select, calibration and differential bits
  task automatic t_chan();
    logic [7:0] s2 [4] = '{8'h00, 8'h20, 8'h40, 8'h08};
    acsc_chan_t ch [4] = '{CH_AIN3_COM, CH_OFFSET_CAL_INPUT, CH_GAIN_CAL_INPUT, CH_PAIR56};
    wr(`ACSC_RS_SETUP1, 8'hbf);
    foreach (s2[i]) begin
      wr(`ACSC_RS_SETUP2, s2[i]);
      repeat (2) @(negedge clk_sys);
      `ACSC_CHK(conv_chan_q, ch[i])
    end
  endtask

  // setup two mirrors and the halved master clock
  task automatic t_mirror();
    logic [7:0] d;
    int n;
    wr(`ACSC_RS_SETUP2, 8'h1d);
    repeat (2) @(negedge clk_sys);
    `ACSC_CHK({input_buffer_en_q, input_mode_a_q, burnout_source_en_q}, 3'h7)
    `ACSC_CHK(clock_prescale_half_q, 1'b1)
    `ACSC_CHK(mod_ratio_q, 2'h3)
    rd(`ACSC_RS_SETUP2, d);
    `ACSC_CHK(d, 8'h1d)
    wait_word(n);
    wait_word(n);
    `ACSC_CHK(n, 4096)
    wr(`ACSC_RS_SETUP2, 8'h00);
  endtask

  // scan with calibration pair, select bits ignored, then differential pairs
  task automatic t_scan();
    acsc_chan_t seq [7] = '{CH_AIN1_COM, CH_AIN2_COM, CH_AIN3_COM, CH_AIN4_COM,
      CH_AIN5_COM, CH_OFFSET_CAL_INPUT, CH_GAIN_CAL_INPUT};
    logic [1:0] tf [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
    acsc_chan_t pair [3] = '{CH_PAIR12, CH_PAIR34, CH_PAIR56};
    logic [7:0] d;
    int n;
    wr(`ACSC_RS_SETUP2, 8'ha0);
    for (int k = 0; k < 8; k++) begin
      if (k > 0) wait_word(n);
      repeat (2) @(negedge clk_sys);
      `ACSC_CHK(conv_chan_q, seq[k % 7])
      `ACSC_CHK(tf_sel_q, tf[k % 7])
      if (k > 0) begin
        rd(`ACSC_RS_DATA, d);
        `ACSC_CHK(d, {4'h0, seq[k - 1]})
      end
    end
    wr(`ACSC_RS_SETUP2, 8'h88);
    for (int k = 0; k < 4; k++) begin
      if (k > 0) wait_word(n);
      repeat (2) @(negedge clk_sys);
      `ACSC_CHK(conv_chan_q, pair[k % 3])
      `ACSC_CHK(tf_sel_q, tf[2 * (k % 3)])
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #900000;
    failures++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
    t_rate();
    t_sinc3();
    t_hold();
    t_chan();
    t_mirror();
    t_scan();
    test_done();
  end
endmodule
